// ===== pkg/fdc_qual_pkg.sv
package fdc_qual_pkg;

  // wishbone register byte offsets
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATE = 4'h4;
  localparam logic [3:0] REG_EVENTS = 4'h8;
  localparam logic [3:0] REG_MASK = 4'hC;

  // config fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DMA_SEL_BIT = 2;

  // operations register: bit holding the dma gate
  localparam int OPS_DMA_GATE_BIT = 0;

  // event bit positions
  localparam int EV_XFER_END = 0;
  localparam int EV_CMD_DONE = 1;
  localparam int EV_ABNORMAL = 2;
  localparam int EV_MEDIA_SWAP = 3;
  localparam int EV_WIDTH = 4;

  // state register fields
  localparam int ST_OPS_LSB = 0;
  localparam int ST_CTL_LSB = 2;
  localparam int ST_ALT_BIT = 4;
  localparam int ST_IRQ_BIT = 5;
  localparam int ST_MODE_LSB = 6;

  // control register code that picks the alternate rate clock
  localparam logic [1:0] RATE_ALT_CODE = 2'h1;

  // reset values
  localparam logic [1:0] OPS_RESET = 2'h0;
  localparam logic [1:0] CTL_RESET = 2'h0;
  localparam logic [EV_WIDTH-1:0] MASK_RESET = 4'h0;

  typedef enum logic [1:0] {
    MODE_BASE = 2'b00,
    MODE_SPECIAL = 2'b01,
    MODE_ALT_AT = 2'b10
  } op_mode_t;

  // host pins as sampled, strobes active low
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic port_select_line;
    logic dma_ack_in_n;
    logic transfer_end_in;
    logic ops_reg_load_sel_n;
    logic ctl_reg_load_sel_n;
    logic media_swap_report_en_n;
    logic media_swap_in_n;
    logic [7:0] data;
  } host_pins_t;

  // signals from the sequencer core
  typedef struct packed {
    logic exec_done;
    logic byte_req;
    logic [7:0] main_status;
    logic [7:0] read_data;
  } core_side_t;

endpackage

// ===== src/fdc_host_signal_qualifier.sv
`timescale 1ns/1ps
// What this block does
// R1: transfer end is taken as end of transfer, needing dma acknowledge in dma execution but not in programmed io outside alternate-at mode.
// R2: in special or alternate-at mode, an acknowledge qualifies transfer end only while the dma gate bit is set.
// R3: in alternate-at mode, transfer end always needs dma acknowledge, dma or not.
// R4: a programmed io command in alternate-at mode reports abnormal termination when it completes.
// R5: the data bus is 8 bits, bit 0 lsb, bit 7 msb, and is driven only during reads.
// R6: the dma request asks for one byte; in special or alternate-at mode it floats unless the gate bit is set.
// R7: interrupt rises on command completion, and in non-dma mode also on each byte request.
// R8: interrupt is always driven in base mode and floats in other modes unless the gate bit is set.
// R9: with swap reporting enabled low, a read with the control decode low puts media swap status on data bit seven.
// R10: the operations decode with the write strobe latches the two low data bits into the operations register.
// R11: the control decode with the write strobe latches the two low data bits into the control register.
// R12: reset idles the sequencer, resets outputs and selects base mode.
// R13: the drive sends raw read data where each falling edge is one flux transition.
// R14: the alternate rate clock is used only when the control register selects that rate.
// R15: dma acknowledge acts as a selected data port access, honoured in special or alternate-at mode only with the gate set.
// R16: the host uses the port select line high for data, low for status, and never writes with it low.
// R17: in base mode the gate bit is ignored and acknowledge, transfer end and output enables count as qualified.
module fdc_host_signal_qualifier
  import fdc_qual_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic INT_O,
  // host pins
  input wire host_pins_t HOST_I,
  output logic [7:0] DB_O,
  output logic DB_OE_O,
  output logic DMA_REQ_O,
  output logic DMA_REQ_OE_O,
  output logic IRQ_O,
  output logic IRQ_OE_O,
  // sequencer core side
  input wire core_side_t CORE_I,
  output logic DATA_WR_STB_O,
  output logic [7:0] DATA_WR_O,
  output logic DATA_RD_STB_O,
  output logic XFER_END_O,
  output logic ABNORMAL_END_O,
  output logic SEQ_IDLE_O,
  // drive and clock side
  input wire logic RAW_READ_STREAM_I,
  output logic FLUX_EDGE_O,
  output logic ALT_RATE_CLOCK_SEL_O
);

  op_mode_t mode_q;
  logic dma_sel_q;
  logic [1:0] ops_q;
  logic [1:0] ctl_q;
  logic [EV_WIDTH-1:0] events_q;
  logic [EV_WIDTH-1:0] mask_q;
  logic irq_pend_q;
  logic tc_seen_q;
  logic raw_prev_q;
  logic swap_rd_prev_q;
  logic rd_prev_q;
  logic wr_prev_q;

  // decode shared by several strobes
  function automatic logic gate_open(input op_mode_t m, input logic gate);
    gate_open = (m == MODE_BASE) | gate;
  endfunction

  // wishbone write decode shared by the config, events and mask registers
  function automatic logic wb_write_hit(input logic wr, input logic [3:0] adr, input logic [3:0] off,
    input logic [3:0] sel);
    wb_write_hit = wr && (adr == off) && sel[0];
  endfunction

  logic is_base;
  logic is_alt_at;
  logic gate_ok;
  logic dma_ack_in_ok;
  logic need_dma_ack_in;
  logic tc_qual;
  logic data_access;
  logic host_rd;
  logic host_wr;
  logic swap_rd;
  logic [EV_WIDTH-1:0] ev_set;
  logic bus_req;
  logic bus_wr;
  logic cfg_wr;
  logic events_wr;
  logic mask_wr;
  logic [31:0] rd_word;

  assign is_base = (mode_q == MODE_BASE);
  assign is_alt_at = (mode_q == MODE_ALT_AT);
  assign gate_ok = gate_open(mode_q, ops_q[OPS_DMA_GATE_BIT]); // R17
  assign dma_ack_in_ok = !HOST_I.dma_ack_in_n && gate_ok; // R15
  assign need_dma_ack_in = is_alt_at || dma_sel_q; // R1 R3
  assign tc_qual = HOST_I.transfer_end_in && (!need_dma_ack_in || dma_ack_in_ok); // R1 R2
  // acknowledge stands in for chip select with the data port picked
  assign data_access = (!HOST_I.cs_n && HOST_I.port_select_line) || dma_ack_in_ok; // R15
  assign host_rd = !HOST_I.rd_n && (!HOST_I.cs_n || dma_ack_in_ok);
  // writes with the port select low are not expected from the host
  assign host_wr = !HOST_I.wr_n && data_access; // R16
  assign swap_rd = !HOST_I.rd_n && !HOST_I.ctl_reg_load_sel_n && !HOST_I.media_swap_report_en_n; // R9
  assign bus_req = CYC_I && STB_I && !ACK_O;
  assign bus_wr = bus_req && WE_I;
  assign cfg_wr = wb_write_hit(bus_wr, ADR_I, REG_CONFIG, SEL_I);
  assign events_wr = wb_write_hit(bus_wr, ADR_I, REG_EVENTS, SEL_I);
  assign mask_wr = wb_write_hit(bus_wr, ADR_I, REG_MASK, SEL_I);

  assign ev_set[EV_XFER_END] = tc_qual && !tc_seen_q;
  assign ev_set[EV_CMD_DONE] = CORE_I.exec_done;
  assign ev_set[EV_ABNORMAL] = CORE_I.exec_done && is_alt_at && !dma_sel_q; // R4
  assign ev_set[EV_MEDIA_SWAP] = swap_rd && !swap_rd_prev_q && !HOST_I.media_swap_in_n;

  // software configuration
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      mode_q <= MODE_BASE; // R12
      dma_sel_q <= 1'b0;
      mask_q <= MASK_RESET;
    end else if (cfg_wr) begin
      case (DAT_I[CFG_MODE_LSB +: 2])
        2'h0: mode_q <= MODE_BASE;
        2'h1: mode_q <= MODE_SPECIAL;
        2'h2: mode_q <= MODE_ALT_AT;
        default: mode_q <= mode_q;
      endcase
      dma_sel_q <= DAT_I[CFG_DMA_SEL_BIT];
    end else if (mask_wr) begin
      mask_q <= DAT_I[EV_WIDTH-1:0];
    end
  end

  // operations and control registers, latched from the host pins
  // no chip select here: each decode pin is its own select
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ops_q <= OPS_RESET;
      ctl_q <= CTL_RESET;
    end else begin
      if (!HOST_I.wr_n && !HOST_I.ops_reg_load_sel_n) begin
        ops_q <= HOST_I.data[1:0]; // R10
      end
      if (!HOST_I.wr_n && !HOST_I.ctl_reg_load_sel_n) begin
        ctl_q <= HOST_I.data[1:0]; // R11
      end
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      events_q <= '0;
    end else if (events_wr) begin
      events_q <= (events_q & ~DAT_I[EV_WIDTH-1:0]) | ev_set;
    end else begin
      events_q <= events_q | ev_set;
    end
  end

  // host interrupt pending: cleared by a data port read, set wins
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      irq_pend_q <= 1'b0;
    end else if (CORE_I.exec_done) begin
      irq_pend_q <= 1'b1; // R7
    end else if (host_rd && data_access && !rd_prev_q) begin
      irq_pend_q <= 1'b0;
    end
  end

  // edge history
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      tc_seen_q <= 1'b0;
      raw_prev_q <= 1'b1;
      swap_rd_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      tc_seen_q <= tc_qual;
      raw_prev_q <= RAW_READ_STREAM_I;
      swap_rd_prev_q <= swap_rd;
      rd_prev_q <= host_rd;
      wr_prev_q <= host_wr;
    end
  end

  // host data bus, driven only while a read is in progress
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      DB_O <= 8'h00;
      DB_OE_O <= 1'b0;
    end else begin
      DB_OE_O <= host_rd || swap_rd; // R5
      if (swap_rd) begin
        DB_O <= {!HOST_I.media_swap_in_n, 7'h00}; // R9
      end else if (data_access) begin
        DB_O <= CORE_I.read_data;
      end else begin
        DB_O <= CORE_I.main_status;
      end
    end
  end

  // request outputs and their enables
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      DMA_REQ_O <= 1'b0;
      DMA_REQ_OE_O <= 1'b1;
      IRQ_O <= 1'b0;
      IRQ_OE_O <= 1'b1;
    end else begin
      DMA_REQ_O <= CORE_I.byte_req && dma_sel_q; // R6
      DMA_REQ_OE_O <= gate_ok; // R6
      IRQ_O <= irq_pend_q || (CORE_I.byte_req && !dma_sel_q); // R7
      IRQ_OE_O <= gate_ok; // R8
    end
  end

  // strobes toward the core; one pulse per data port access
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      DATA_WR_STB_O <= 1'b0;
      DATA_WR_O <= 8'h00;
      DATA_RD_STB_O <= 1'b0;
      XFER_END_O <= 1'b0;
      ABNORMAL_END_O <= 1'b0;
      SEQ_IDLE_O <= 1'b1;
      FLUX_EDGE_O <= 1'b0;
      ALT_RATE_CLOCK_SEL_O <= 1'b0;
    end else begin
      DATA_WR_STB_O <= host_wr && !wr_prev_q;
      if (host_wr) begin
        DATA_WR_O <= HOST_I.data;
      end
      DATA_RD_STB_O <= host_rd && data_access && !rd_prev_q;
      XFER_END_O <= ev_set[EV_XFER_END]; // R1
      ABNORMAL_END_O <= ev_set[EV_ABNORMAL]; // R4
      // idle from reset until the host first writes the data port or reads either port
      if (host_wr || host_rd) begin
        SEQ_IDLE_O <= 1'b0;
      end
      FLUX_EDGE_O <= raw_prev_q && !RAW_READ_STREAM_I; // R13
      ALT_RATE_CLOCK_SEL_O <= (ctl_q == RATE_ALT_CODE); // R14
    end
  end

  // register read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (ADR_I)
      REG_CONFIG: begin
        rd_word[CFG_MODE_LSB +: 2] = mode_q;
        rd_word[CFG_DMA_SEL_BIT] = dma_sel_q;
      end
      REG_STATE: begin
        rd_word[ST_OPS_LSB +: 2] = ops_q;
        rd_word[ST_CTL_LSB +: 2] = ctl_q;
        rd_word[ST_ALT_BIT] = ALT_RATE_CLOCK_SEL_O;
        rd_word[ST_IRQ_BIT] = irq_pend_q;
        rd_word[ST_MODE_LSB +: 2] = mode_q;
      end
      REG_EVENTS: rd_word[EV_WIDTH-1:0] = events_q;
      REG_MASK: rd_word[EV_WIDTH-1:0] = mask_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // wishbone answer: one wait state, unmapped reads return zero
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= bus_req;
      DAT_O <= 32'h0000_0000;
      if (bus_req && !WE_I) begin
        DAT_O <= rd_word;
      end
    end
  end

  // level interrupt toward software
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      INT_O <= 1'b0;
    end else begin
      INT_O <= |(events_q & mask_q);
    end
  end

endmodule // fdc_host_signal_qualifier

// ===== verification/fdc_qual_properties.sv
`timescale 1ns/1ps
module fdc_qual_properties
  import fdc_qual_pkg::*;
(
  // clock, reset, bus answer
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic ACK_O,
  // host and core side
  input wire host_pins_t HOST_I,
  input wire core_side_t CORE_I,
  input wire logic [7:0] DB_O,
  input wire logic DB_OE_O,
  input wire logic DMA_REQ_OE_O,
  input wire logic XFER_END_O,
  input wire logic ABNORMAL_END_O,
  input wire logic SEQ_IDLE_O,
  input wire logic RAW_READ_STREAM_I,
  input wire logic FLUX_EDGE_O,
  input wire logic ALT_RATE_CLOCK_SEL_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  // write seen one or two cycles back, covers either register depth
  logic hit1_q;
  logic hit2_q;
  always_ff @(posedge CLK_SYS_I) begin
    hit1_q <= !HOST_I.wr_n && !HOST_I.ctl_reg_load_sel_n;
    hit2_q <= hit1_q;
  end
  a_ack_one_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack held too long");
  a_reset_base_mode: assert property ($fell(SRST_I) |-> DMA_REQ_OE_O && SEQ_IDLE_O && !DB_OE_O)
    else $error("reset state wrong");
  a_bus_read_only: assert property (DB_OE_O |-> !$past(HOST_I.rd_n))
    else $error("bus driven outside read");
  a_swap_bit_seven: assert property (!HOST_I.rd_n && !HOST_I.ctl_reg_load_sel_n
    && !HOST_I.media_swap_report_en_n && !HOST_I.media_swap_in_n |=> DB_OE_O && DB_O[7])
    else $error("swap status missing");
  a_xfer_end_cause: assert property (XFER_END_O |-> $past(HOST_I.transfer_end_in)
    || $past(HOST_I.transfer_end_in, 2))
    else $error("end pulse without cause");
  a_abnormal_cause: assert property (ABNORMAL_END_O |-> $past(CORE_I.exec_done))
    else $error("abnormal without completion");
  a_flux_edge_pulse: assert property ($fell(RAW_READ_STREAM_I) |=> FLUX_EDGE_O)
    else $error("flux edge missed");
  a_alt_sel_cause: assert property ($changed(ALT_RATE_CLOCK_SEL_O) |-> hit1_q || hit2_q)
    else $error("rate select moved alone");
  c_swap_read: cover property (DB_OE_O && DB_O[7]);
  c_abnormal: cover property (ABNORMAL_END_O);
  c_xfer_end: cover property (XFER_END_O);
endmodule // fdc_qual_properties

// ===== verification/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model
  import fdc_qual_pkg::*;
#(
  parameter host_pins_t IDLE = 18'h3EF00
)
(
  // clock and device bus
  input wire logic clk_i,
  input wire logic [7:0] db_i,
  input wire logic db_oe_i,
  // pins toward the device
  output host_pins_t pins_o,
  output logic raw_o
);
  host_pins_t drv_q = IDLE;
  logic [7:0] last_q = 8'h00;
  // no pull-up on the bus, so a released bus toggles
  always_comb begin
    pins_o = drv_q;
    pins_o.data = db_oe_i ? db_i : (drv_q.wr_n ? ~last_q : drv_q.data);
  end
  always_ff @(posedge clk_i) last_q <= pins_o.data;
  initial raw_o = 1'b1;
  task automatic drive(input host_pins_t p, input int n);
    host_pins_t w;
    w = p;
    if (!w.wr_n) w.port_select_line = 1'b1;
    drv_q <= w;
    repeat (n) @(posedge clk_i);
    drv_q <= IDLE;
    @(posedge clk_i);
  endtask
  task automatic flux();
    raw_o <= 1'b0;
    @(posedge clk_i);
    raw_o <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule // host_bus_model

// ===== verification/tb_fdc_host_signal_qualifier.sv
`timescale 1ns/1ps
module tb_fdc_host_signal_qualifier
  import fdc_qual_pkg::*;
;
  typedef struct packed {
    logic [1:0] mode;
    logic dsel;
    logic gate;
    logic ackn;
    logic xend;
    logic oe;
  } row_t;
  localparam host_pins_t IDLE = 18'h3EF00;
  // mode dsel gate ackn xend oe
  localparam row_t ROWS [8] = '{7'h13, 7'h15, 7'h07, 7'h30, 7'h3B, 7'h2F, 7'h4D, 7'h4B};
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  core_side_t core = '{1'b0, 1'b0, 8'h5A, 8'hC3};
  host_pins_t pins, p;
  logic [7:0] db, wdat;
  logic raw, ack, intr, db_oe, dma_oe, irq, irq_oe, idle, alt, dreq, wstb, rstb, xend_o, abn, flux;
  int fail_count = 0, compares = 0;
  initial forever #12.5 clk = ~clk;
  fdc_host_signal_qualifier dut (.CLK_SYS_I(clk), .SRST_I(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack), .INT_O(intr), .HOST_I(pins),
    .DB_O(db), .DB_OE_O(db_oe), .DMA_REQ_O(dreq), .DMA_REQ_OE_O(dma_oe), .IRQ_O(irq), .IRQ_OE_O(irq_oe),
    .CORE_I(core), .DATA_WR_STB_O(wstb), .DATA_WR_O(wdat), .DATA_RD_STB_O(rstb), .XFER_END_O(xend_o),
    .ABNORMAL_END_O(abn), .SEQ_IDLE_O(idle), .RAW_READ_STREAM_I(raw), .FLUX_EDGE_O(flux),
    .ALT_RATE_CLOCK_SEL_O(alt));
  host_bus_model #(.IDLE(IDLE)) host (.clk_i(clk), .db_i(db), .db_oe_i(db_oe), .pins_o(pins), .raw_o(raw));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      results();
    end else begin
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  // latch through a decode, ctl=0 picks the operations register
  task automatic pw(input logic ctl, input logic [7:0] d);
    host_pins_t w;
    w = IDLE;
    w.wr_n = 1'b0;
    w.ops_reg_load_sel_n = ctl;
    w.ctl_reg_load_sel_n = !ctl;
    w.data = d;
    host.drive(w, 1);
  endtask
  task automatic rdc(input host_pins_t w, input logic s, input logic [7:0] e);
    fork
      host.drive(w, 2);
      begin
        repeat (2) @(posedge clk);
        chk("db", {db_oe, rstb, db}, {1'b1, s, e});
      end
    join
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("oe_init", {idle, irq_oe, dma_oe}, 3'h7);
    foreach (ROWS[i]) begin
      wb(1'b1, REG_CONFIG, {29'h0, ROWS[i].dsel, ROWS[i].mode});
      pw(1'b0, {7'h00, ROWS[i].gate});
      p = IDLE;
      p.dma_ack_in_n = ROWS[i].ackn;
      p.transfer_end_in = 1'b1;
      host.drive(p, 1);
      chk("xfer_pulse", xend_o, ROWS[i].xend);
      chk("irq_oe", irq_oe, ROWS[i].oe);
      chk("dma_oe", dma_oe, ROWS[i].oe);
      wb(1'b0, REG_EVENTS, 32'h0);
      chk("xfer_end", q[EV_XFER_END], ROWS[i].xend);
      wb(1'b1, REG_EVENTS, 32'hF);
    end
    for (int k = 0; k < 2; k++) begin
      pw(1'b1, k ? 8'h02 : 8'hFD);
      wb(1'b0, REG_STATE, 32'h0);
      chk("ctl", q[3:2], k ? 2'h2 : 2'h1);
      chk("alt", alt, !k);
    end
    p = IDLE;
    p.rd_n = 1'b0;
    p.cs_n = 1'b0;
    p.port_select_line = 1'b0;
    p.ctl_reg_load_sel_n = 1'b0;
    p.media_swap_report_en_n = 1'b0;
    p.media_swap_in_n = 1'b0;
    rdc(p, 1'b0, 8'h80);
    wb(1'b1, REG_EVENTS, 32'hF);
    core.exec_done <= 1'b1;
    @(posedge clk);
    core.exec_done <= 1'b0;
    @(posedge clk);
    chk("abn", abn, 1'b1);
    repeat (2) @(posedge clk);
    chk("int_masked", intr, 1'b0);
    chk("irq_done", irq, 1'b1);
    wb(1'b1, REG_MASK, 32'h4);
    repeat (2) @(posedge clk);
    chk("int_abn", intr, 1'b1);
    wb(1'b1, REG_EVENTS, 32'h4);
    repeat (2) @(posedge clk);
    chk("int_clr", intr, 1'b0);
    p = IDLE;
    p.rd_n = 1'b0;
    p.cs_n = 1'b0;
    rdc(p, 1'b1, 8'hC3);
    chk("irq_clr", irq, 1'b0);
    core.byte_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq_req", irq, 1'b1);
    chk("dreq_pio", dreq, 1'b0);
    core.byte_req <= 1'b0;
    wb(1'b1, REG_CONFIG, 32'h0000_0006);
    core.byte_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk("dreq_dma", {dreq, dma_oe}, 2'h3);
    chk("irq_dma", irq, 1'b0);
    core.byte_req <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      p = IDLE;
      p.wr_n = 1'b0;
      p.cs_n = k[0];
      p.dma_ack_in_n = !k[0];
      p.data = k ? 8'h3C : 8'hA5;
      host.drive(p, 1);
      chk("wr_stb", {wstb, wdat}, {1'b1, p.data});
      @(posedge clk);
      chk("wr_stb_end", wstb, 1'b0);
    end
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    host.flux();
    chk("flux", flux, 1'b1);
    chk("idle_busy", idle, 1'b0);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("oe_rst", {idle, irq_oe, dma_oe}, 3'h7);
    wb(1'b0, REG_STATE, 32'h0);
    chk("state_rst", q, 32'h0);
    results();
  end
endmodule // tb_fdc_host_signal_qualifier
bind fdc_host_signal_qualifier fdc_qual_properties props (.CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .ACK_O(ACK_O),
  .HOST_I(HOST_I), .CORE_I(CORE_I), .DB_O(DB_O), .DB_OE_O(DB_OE_O), .DMA_REQ_OE_O(DMA_REQ_OE_O),
  .XFER_END_O(XFER_END_O), .ABNORMAL_END_O(ABNORMAL_END_O), .SEQ_IDLE_O(SEQ_IDLE_O),
  .RAW_READ_STREAM_I(RAW_READ_STREAM_I), .FLUX_EDGE_O(FLUX_EDGE_O), .ALT_RATE_CLOCK_SEL_O(ALT_RATE_CLOCK_SEL_O));
